// >>> bench/dsp_ctrl_model.sv
// Purpose: behavioural memory controller facing the ddr sram port
// Assumes: k and c run at 64 ns (c held high while c_held_i is set), phases unrelated to the core clock
// Notes:   released address, data and mask lines show the inverse of their last value
`timescale 1ns/1ps
`include "dsp_consts.svh"

module dsp_ctrl_model (
   input  wire logic              c_held_i,
   output logic                   k_clk_o,
   output logic                   c_clk_o,
   output logic                   load_strobe_n_o,
   output logic                   rd_wr_sel_o,
   output logic [`DSP_ADDR_W-1:0] addr_o,
   output logic [`DSP_DATA_W-1:0] wr_bus_o,
   output logic [`DSP_LANES-1:0]  lane_wr_mask_n_o
);
   initial begin
      k_clk_o          = 1'b0;
      load_strobe_n_o  = 1'b1;
      rd_wr_sel_o      = 1'b0;
      addr_o           = '0;
      wr_bus_o         = '0;
      lane_wr_mask_n_o = '1;
      #7;
      // falling edge serves as the complementary input clock
      forever #32 k_clk_o = ~k_clk_o;
   end
   initial begin
      c_clk_o = 1'b1;
      #23;
      forever #32 c_clk_o = c_held_i | ~c_clk_o;
   end

   task automatic send(input logic wr, input logic [`DSP_ADDR_W-1:0] a,
                       input logic [`DSP_DATA_W-1:0] d0, d1,
                       input logic [`DSP_LANES-1:0] m0, m1);
      @(posedge k_clk_o);
      load_strobe_n_o  <= 1'b0;
      rd_wr_sel_o      <= ~wr;
      addr_o           <= a;
      wr_bus_o         <= d0;
      lane_wr_mask_n_o <= m0;
      @(posedge k_clk_o);
      load_strobe_n_o  <= 1'b1;
      addr_o           <= ~a;
      wr_bus_o         <= d1;
      lane_wr_mask_n_o <= m1;
      @(posedge k_clk_o);
      wr_bus_o         <= ~d1;
      lane_wr_mask_n_o <= ~m1;
   endtask : send

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge k_clk_o);
         addr_o      <= ~addr_o;
         rd_wr_sel_o <= ~rd_wr_sel_o;
      end
   endtask : idle
endmodule : dsp_ctrl_model

// >>> bench/dsp_port_checker.sv
// Purpose: concurrent checks at the ports of the ddr sram port
// Assumes: the strap picks k_clk_i or c_clk_i as launch clock
// Notes:   event counters cross domains untimed, fine for checking
`timescale 1ns/1ps
`include "dsp_consts.svh"

module dsp_port_checker (
   input wire logic                   core_clk_i,
   input wire logic                   nrst_i,
   input wire logic                   ce_i,
   input wire logic                   k_clk_i,
   input wire logic                   c_clk_i,
   input wire logic                   c_tied_high_i,
   input wire logic                   load_strobe_n_i,
   input wire logic [`DSP_DATA_W-1:0] rd_bus_out_o,
   input wire logic                   rd_drive_o,
   input wire logic [1:0]             echo_timing_out_o,
   input wire logic                   usr_req_valid_o,
   input wire logic                   usr_req_ready_i,
   input wire logic [`DSP_ADDR_W-1:0] usr_req_addr_o,
   input wire logic [`DSP_PAIR_W-1:0] usr_req_data_o,
   input wire logic                   usr_rsp_valid_i,
   input wire logic [`DSP_PAIR_W-1:0] usr_rsp_data_i,
   input wire logic                   usr_rsp_ready_o
);
   wire logic              l_clk = c_tied_high_i ? k_clk_i : c_clk_i;
   int unsigned            loads_q, pops_q, rsps_q, bursts_q;
   logic [`DSP_PAIR_W-1:0] last_rsp_q;

   always_ff @(posedge k_clk_i or negedge nrst_i) begin
      if (!nrst_i) loads_q <= 0;
      else if (!load_strobe_n_i) loads_q <= loads_q + 1;
   end
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pops_q     <= 0;
         rsps_q     <= 0;
         last_rsp_q <= '0;
      end else if (ce_i) begin
         if (usr_req_valid_o && usr_req_ready_i) pops_q <= pops_q + 1;
         if (usr_rsp_valid_i && usr_rsp_ready_o) begin
            rsps_q     <= rsps_q + 1;
            last_rsp_q <= usr_rsp_data_i;
         end
      end
   end
   always_ff @(posedge l_clk or negedge nrst_i) begin
      if (!nrst_i) bursts_q <= 0;
      else if ($rose(rd_drive_o)) bursts_q <= bursts_q + 1;
   end

   property p_req_hold;
      @(posedge core_clk_i) disable iff (!nrst_i)
      usr_req_valid_o && !usr_req_ready_i |=> usr_req_valid_o &&
         $stable(usr_req_addr_o) && $stable(usr_req_data_o);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request changed while stalled");
   // more records than loaded commands means an idle cycle was taken
   property p_no_idle_cmd;
      @(posedge core_clk_i) disable iff (!nrst_i) pops_q <= loads_q;
   endproperty
   a_no_idle_cmd: assert property (p_no_idle_cmd)
      else $error("record without a loaded command");
   property p_rd_src;
      @(posedge l_clk) disable iff (!nrst_i)
      $rose(rd_drive_o) |-> rsps_q > bursts_q;
   endproperty
   a_rd_src: assert property (p_rd_src)
      else $error("read data driven without a read");
   property p_burst_len;
      @(posedge l_clk) disable iff (!nrst_i)
      $rose(rd_drive_o) |=> rd_drive_o ##1 !rd_drive_o;
   endproperty
   a_burst_len: assert property (p_burst_len)
      else $error("read burst length wrong");
   property p_first_word;
      @(posedge l_clk) disable iff (!nrst_i)
      $rose(rd_drive_o) |-> rd_bus_out_o == last_rsp_q[17:0];
   endproperty
   a_first_word: assert property (p_first_word)
      else $error("first read word wrong");
   property p_second_word;
      @(posedge l_clk) disable iff (!nrst_i)
      $rose(rd_drive_o) |=> rd_bus_out_o == last_rsp_q[35:18];
   endproperty
   a_second_word: assert property (p_second_word)
      else $error("second read word wrong");
   property p_rsp_take;
      @(posedge core_clk_i) disable iff (!nrst_i)
      usr_rsp_valid_i && usr_rsp_ready_o && ce_i |=> !usr_rsp_ready_o;
   endproperty
   a_rsp_take: assert property (p_rsp_take)
      else $error("response ready stayed high");
   property p_echo;
      @(posedge core_clk_i) disable iff (!nrst_i)
      echo_timing_out_o == {~l_clk, l_clk};
   endproperty
   a_echo: assert property (p_echo)
      else $error("echo clock not following launch clock");

   c_pop: cover property (@(posedge core_clk_i)
      usr_req_valid_o && usr_req_ready_i);
   c_rsp: cover property (@(posedge core_clk_i)
      usr_rsp_valid_i && usr_rsp_ready_o);
   c_burst: cover property (@(posedge l_clk) $rose(rd_drive_o));
endmodule : dsp_port_checker

// >>> bench/test_dsp_port.sv
// Purpose: self-checking bench of the ddr sram port
// Assumes: far side is dsp_ctrl_model, user side is driven here
// Notes:   the strap only changes under reset
`timescale 1ns/1ps
`include "dsp_consts.svh"

module test_dsp_port;
   logic                   core_clk_i, nrst_i, ce_i, c_tied_high_i;
   logic                   k_clk_i, c_clk_i, load_strobe_n_i, rd_wr_sel_i;
   logic [`DSP_ADDR_W-1:0] addr_i, usr_req_addr_o;
   logic [`DSP_DATA_W-1:0] wr_bus_in_i, rd_bus_out_o;
   logic [`DSP_LANES-1:0]  lane_wr_mask_n_i;
   logic [1:0]             echo_timing_out_o;
   logic                   rd_drive_o, link_overrun_o, usr_req_valid_o;
   logic                   usr_req_ready_i, usr_req_wr_o, usr_rsp_valid_i;
   logic                   usr_rsp_ready_o;
   logic [`DSP_PAIR_W-1:0] usr_req_data_o, usr_rsp_data_i;
   logic [`DSP_MASK_W-1:0] usr_req_mask_n_o;
   int                     num_errors, samples_checked, cycles;
   wire logic              l_clk = c_tied_high_i ? k_clk_i : c_clk_i;

   dsp_ctrl_model ctrl (.c_held_i(c_tied_high_i), .k_clk_o(k_clk_i),
      .c_clk_o(c_clk_i), .load_strobe_n_o(load_strobe_n_i),
      .rd_wr_sel_o(rd_wr_sel_i), .addr_o(addr_i), .wr_bus_o(wr_bus_in_i),
      .lane_wr_mask_n_o(lane_wr_mask_n_i));
   dsp_port dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
      .k_clk_i(k_clk_i), .c_clk_i(c_clk_i), .c_tied_high_i(c_tied_high_i),
      .load_strobe_n_i(load_strobe_n_i), .rd_wr_sel_i(rd_wr_sel_i),
      .addr_i(addr_i), .wr_bus_in_i(wr_bus_in_i),
      .lane_wr_mask_n_i(lane_wr_mask_n_i), .rd_bus_out_o(rd_bus_out_o),
      .rd_drive_o(rd_drive_o), .echo_timing_out_o(echo_timing_out_o),
      .link_overrun_o(link_overrun_o), .usr_req_valid_o(usr_req_valid_o),
      .usr_req_ready_i(usr_req_ready_i), .usr_req_wr_o(usr_req_wr_o),
      .usr_req_addr_o(usr_req_addr_o), .usr_req_data_o(usr_req_data_o),
      .usr_req_mask_n_o(usr_req_mask_n_o), .usr_rsp_valid_i(usr_rsp_valid_i),
      .usr_rsp_data_i(usr_rsp_data_i), .usr_rsp_ready_o(usr_rsp_ready_o));

   always #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic do_reset(input logic tied);
      @(posedge core_clk_i);
      nrst_i        <= 1'b0;
      c_tied_high_i <= tied;
      repeat (10) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (20) @(posedge core_clk_i);
   endtask : do_reset
   // takes one record from the user side and judges its fields, data and masks only for writes
   task automatic pop(input logic wr, input logic [19:0] a,
                      input logic [35:0] d, input logic [3:0] m);
      int n = 0;
      @(posedge core_clk_i);
      while (usr_req_valid_o !== 1'b1 && n < 200) begin
         @(posedge core_clk_i);
         n++;
      end
      chk_bit(usr_req_valid_o, 1'b1);
      chk_bit(usr_req_wr_o, wr);
      chk_word(36'(usr_req_addr_o), 36'(a));
      if (wr) begin
         chk_word(usr_req_data_o, d);
         chk_word(36'(usr_req_mask_n_o), 36'(m));
      end
      usr_req_ready_i <= 1'b1;
      @(posedge core_clk_i);
      usr_req_ready_i <= 1'b0;
   endtask : pop
   task automatic rsp_burst(input logic [35:0] w);
      int n = 0;
      usr_rsp_valid_i <= 1'b1;
      usr_rsp_data_i  <= w;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (usr_rsp_ready_o !== 1'b1 && n < 50);
      usr_rsp_valid_i <= 1'b0;
      usr_rsp_data_i  <= ~w;
      n = 0;
      do begin
         @(negedge l_clk);
         #1;
         n++;
      end while (rd_drive_o !== 1'b1 && n < 20);
      chk_word(36'(rd_bus_out_o), 36'(w[17:0]));
      @(posedge l_clk);
      #1;
      chk_word(36'(rd_bus_out_o), 36'(w[35:18]));
      @(posedge l_clk);
      #1;
      chk_bit(rd_drive_o, 1'b0);
   endtask : rsp_burst

   task automatic t_write;
      int i;
      for (i = 0; i < 4; i++) begin
         ctrl.send(1'b1, 20'hf_fffc + 20'(i), 18'h2_5a5a, 18'h1_a5a5 ^ 18'(i),
                   2'(i), 2'(3 - i));
         pop(1'b1, 20'hf_fffc + 20'(i), {18'h1_a5a5 ^ 18'(i), 18'h2_5a5a},
             {2'(3 - i), 2'(i)});
      end
   endtask : t_write
   task automatic t_idle;
      ctrl.idle(8);
      repeat (30) @(posedge core_clk_i);
      chk_bit(usr_req_valid_o, 1'b0);
      chk_bit(rd_drive_o, 1'b0);
   endtask : t_idle
   task automatic t_read(input logic [19:0] a, input logic [35:0] w);
      ctrl.send(1'b0, a, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
      pop(1'b0, a, 36'h0_0000_0000, 4'h0);
      rsp_burst(w);
   endtask : t_read
   // user stalls while three writes arrive; nothing may be lost
   task automatic t_stall;
      int i;
      for (i = 0; i < 3; i++) begin
         ctrl.send(1'b1, 20'(i + 32), 18'(i + 5), 18'(i + 9), 2'(i), 2'h0);
         ctrl.idle(4);
      end
      repeat (40) @(posedge core_clk_i);
      chk_bit(usr_req_valid_o, 1'b1);
      chk_bit(link_overrun_o, 1'b0);
      for (i = 0; i < 3; i++)
         pop(1'b1, 20'(i + 32), {18'(i + 9), 18'(i + 5)}, {2'h0, 2'(i)});
   endtask : t_stall

   initial begin
      core_clk_i      = 1'b0;
      nrst_i          = 1'b0;
      ce_i            = 1'b1;
      c_tied_high_i   = 1'b0;
      usr_req_ready_i = 1'b0;
      usr_rsp_valid_i = 1'b0;
      usr_rsp_data_i  = '0;
      do_reset(1'b0);
      t_write();
      t_idle();
      t_read(20'h0_0005, 36'h9_8765_4321);
      t_stall();
      do_reset(1'b1);
      t_read(20'h7_0001, 36'h3_c3c3_5a5a);
      tally_and_finish();
   end
endmodule : test_dsp_port

bind dsp_port dsp_port_checker chk_i (.core_clk_i(core_clk_i),
   .nrst_i(nrst_i), .ce_i(ce_i), .k_clk_i(k_clk_i), .c_clk_i(c_clk_i),
   .c_tied_high_i(c_tied_high_i), .load_strobe_n_i(load_strobe_n_i),
   .rd_bus_out_o(rd_bus_out_o), .rd_drive_o(rd_drive_o),
   .echo_timing_out_o(echo_timing_out_o), .usr_req_valid_o(usr_req_valid_o),
   .usr_req_ready_i(usr_req_ready_i), .usr_req_addr_o(usr_req_addr_o),
   .usr_req_data_o(usr_req_data_o), .usr_rsp_valid_i(usr_rsp_valid_i),
   .usr_rsp_data_i(usr_rsp_data_i), .usr_rsp_ready_o(usr_rsp_ready_o));

// >>> verilog/dsp_buf2.sv
// Purpose: two-entry valid/ready buffer
// Assumes: one clock, async active-low reset, clock enable
// Notes:   full and empty are exact; input ready falls when both slots hold
`timescale 1ns/1ps
`include "dsp_consts.svh"

module dsp_buf2 #(
   parameter int W = `DSP_REC_W
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         ce_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);

   logic [W-1:0] slot_q [`DSP_BUF_DEPTH];
   logic [W-1:0] slot_d [`DSP_BUF_DEPTH];
   logic         wr_ptr_q;
   logic         wr_ptr_d;
   logic         rd_ptr_q;
   logic         rd_ptr_d;
   logic [1:0]   cnt_q;
   logic [1:0]   cnt_d;
   logic         push;
   logic         pop;

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = slot_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb begin
      wr_ptr_d = wr_ptr_q ^ push;
      rd_ptr_d = rd_ptr_q ^ pop;
      cnt_d    = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   genvar gi;
   generate
      for (gi = 0; gi < `DSP_BUF_DEPTH; gi++) begin : g_slot
         always_comb begin
            slot_d[gi] = slot_q[gi];
            if (push && (wr_ptr_q == 1'(gi))) begin
               slot_d[gi] = in_data_i;
            end
         end
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               slot_q[gi] <= '0;
            end else if (ce_i) begin
               slot_q[gi] <= slot_d[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q    <= 2'h0;
      end else if (ce_i) begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q    <= cnt_d;
      end
   end

endmodule : dsp_buf2

// >>> verilog/dsp_consts.svh
// Purpose: widths and field positions of the ddr sram port
// Assumes: the by-18 organisation
// Notes:   a queued record packs address, direction, two beats, two masks
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH

`define DSP_ADDR_W     20
`define DSP_DATA_W     18
`define DSP_LANES      2
`define DSP_LANE_W     9
`define DSP_BURST      2
`define DSP_PAIR_W     36
`define DSP_MASK_W     4
`define DSP_REC_W      61
`define DSP_BUF_DEPTH  2

`define DSP_REC_MASK_LSB  0
`define DSP_REC_DATA_LSB  4
`define DSP_REC_WR_BIT    40
`define DSP_REC_ADDR_LSB  41

`endif

// >>> verilog/dsp_pkg.sv
// Purpose: shared types of the ddr sram port
// Assumes: constants come from dsp_consts.svh
// Notes:   enums carry no codes
package dsp_pkg;

   typedef enum logic {
      DSP_RSP_IDLE,
      DSP_RSP_WAIT
   } dsp_rsp_state_t;

   typedef enum logic {
      DSP_DIR_WRITE,
      DSP_DIR_READ
   } dsp_dir_t;

endpackage : dsp_pkg

// >>> verilog/dsp_port.sv
// Purpose: command, address and data port of a ddr sram, two-word bursts
// Assumes: input clock pair is k_clk_i and its falling edge; output
//          clock pair is c_clk_i and its falling edge
// Notes:   storage sits behind the user request/response port
//
// Operation
// - address is registered on each rising edge of the input clock with load strobe low.
// - every read or write moves exactly two data words.
// - with load strobe high the cycle is idle and the address is ignored.
// - write data is taken on the rising input clock and on its complement.
// - write and read buses share one data width.
// - read data launches on the output clock pair, or the input pair.
// - read data is driven only after a loaded read command; the port drives it after any accepted user response.
// - with load strobe low, direction high reads and low writes.
// - each write beat has its own byte masks; low mask writes the lane.
// - each lane mask governs its own byte lane of the data bus.
// - the first read word is timed from the complementary output clock.
// - the second read word is timed from the true output clock.
// - echo clocks run freely with read data and stop with their clock.
`timescale 1ns/1ps
`include "dsp_consts.svh"

module dsp_port (
   input  wire logic                      core_clk_i,
   input  wire logic                      nrst_i,
   input  wire logic                      ce_i,
   input  wire logic                      k_clk_i,
   input  wire logic                      c_clk_i,
   input  wire logic                      c_tied_high_i,
   input  wire logic                      load_strobe_n_i,
   input  wire logic                      rd_wr_sel_i,
   input  wire logic [`DSP_ADDR_W-1:0]    addr_i,
   input  wire logic [`DSP_DATA_W-1:0]    wr_bus_in_i,
   input  wire logic [`DSP_LANES-1:0]     lane_wr_mask_n_i,
   output logic      [`DSP_DATA_W-1:0]    rd_bus_out_o,
   output logic                           rd_drive_o,
   output logic      [1:0]                echo_timing_out_o,
   output logic                           link_overrun_o,
   output logic                           usr_req_valid_o,
   input  wire logic                      usr_req_ready_i,
   output logic                           usr_req_wr_o,
   output logic      [`DSP_ADDR_W-1:0]    usr_req_addr_o,
   output logic      [`DSP_PAIR_W-1:0]    usr_req_data_o,
   output logic      [`DSP_MASK_W-1:0]    usr_req_mask_n_o,
   input  wire logic                      usr_rsp_valid_i,
   input  wire logic [`DSP_PAIR_W-1:0]    usr_rsp_data_i,
   output logic                           usr_rsp_ready_o
);

   // ---------------- link domain (input clock pair) ----------------
   logic [1:0]              k_rst_q;
   logic                    k_rst_n;
   logic                    cmd_v_q;
   logic                    cmd_v_d;
   dsp_pkg::dsp_dir_t       cmd_dir_q;
   dsp_pkg::dsp_dir_t       cmd_dir_d;
   logic [`DSP_ADDR_W-1:0]  cmd_addr_q;
   logic [`DSP_ADDR_W-1:0]  cmd_addr_d;
   logic [`DSP_DATA_W-1:0]  b0_data_q;
   logic [`DSP_DATA_W-1:0]  b0_data_d;
   logic [`DSP_LANES-1:0]   b0_mask_q;
   logic [`DSP_LANES-1:0]   b0_mask_d;
   logic [`DSP_DATA_W-1:0]  b1_data_q;
   logic [`DSP_LANES-1:0]   b1_mask_q;
   logic [`DSP_REC_W-1:0]   rec_q;
   logic [`DSP_REC_W-1:0]   rec_d;
   logic                    req_tog_q;
   logic                    req_tog_d;
   logic                    ack_s1_q;
   logic                    ack_s2_q;
   logic                    ovr_q;
   logic                    ovr_d;
   logic                    link_busy;
   logic                    ack_core_q;
   logic                    l_seen_q;

   // reset leaves the link and launch domains only on their own edge; the core domain takes nrst_i directly
   always_ff @(posedge k_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         k_rst_q <= 2'h0;
      end else begin
         k_rst_q <= {k_rst_q[0], 1'b1};
      end
   end
   assign k_rst_n = k_rst_q[1];

   assign link_busy = (req_tog_q != ack_s2_q);

   always_comb begin
      cmd_v_d    = !load_strobe_n_i;
      cmd_dir_d  = cmd_dir_q;
      cmd_addr_d = cmd_addr_q;
      b0_data_d  = wr_bus_in_i;
      b0_mask_d  = lane_wr_mask_n_i;
      if (!load_strobe_n_i) begin
         cmd_addr_d = addr_i;
         cmd_dir_d  = rd_wr_sel_i ? dsp_pkg::DSP_DIR_READ
                                  : dsp_pkg::DSP_DIR_WRITE;
      end
      // an idle cycle leaves the address register untouched
      rec_d     = rec_q;
      req_tog_d = req_tog_q;
      ovr_d     = ovr_q;
      if (cmd_v_q) begin
         if (link_busy) begin
            // the device cannot stall the controller: a burst that finds
            // the crossing still occupied is lost and flagged
            ovr_d = 1'b1;
         end else begin
            // both beats of the burst travel as one record
            rec_d = {cmd_addr_q,
                     (cmd_dir_q == dsp_pkg::DSP_DIR_READ),
                     b1_data_q, b0_data_q,
                     b1_mask_q, b0_mask_q};
            req_tog_d = ~req_tog_q;
         end
      end
   end

   always_ff @(posedge k_clk_i or negedge k_rst_n) begin
      if (!k_rst_n) begin
         cmd_v_q    <= 1'b0;
         cmd_dir_q  <= dsp_pkg::DSP_DIR_WRITE;
         cmd_addr_q <= '0;
         b0_data_q  <= '0;
         b0_mask_q  <= '1;
         rec_q      <= '0;
         req_tog_q  <= 1'b0;
         ack_s1_q   <= 1'b0;
         ack_s2_q   <= 1'b0;
         ovr_q      <= 1'b0;
      end else begin
         cmd_v_q    <= cmd_v_d;
         cmd_dir_q  <= cmd_dir_d;
         cmd_addr_q <= cmd_addr_d;
         b0_data_q  <= b0_data_d;
         b0_mask_q  <= b0_mask_d;
         rec_q      <= rec_d;
         req_tog_q  <= req_tog_d;
         ack_s1_q   <= ack_core_q;
         ack_s2_q   <= ack_s1_q;
         ovr_q      <= ovr_d;
      end
   end

   // second beat on the rising edge of the complementary input clock,
   // taken as the falling edge of the true one
   always_ff @(negedge k_clk_i or negedge k_rst_n) begin
      if (!k_rst_n) begin
         b1_data_q <= '0;
         b1_mask_q <= '1;
      end else begin
         b1_data_q <= wr_bus_in_i;
         b1_mask_q <= lane_wr_mask_n_i;
      end
   end

   assign link_overrun_o = ovr_q;

   // ---------------- core domain ----------------
   logic                    req_s1_q;
   logic                    req_s2_q;
   logic                    ack_core_d;
   logic                    buf_in_valid;
   logic                    buf_in_ready;
   logic                    buf_out_valid;
   logic [`DSP_REC_W-1:0]   buf_out_data;
   dsp_pkg::dsp_rsp_state_t rsp_st_q;
   dsp_pkg::dsp_rsp_state_t rsp_st_d;
   logic [`DSP_PAIR_W-1:0]  rsp_data_q;
   logic [`DSP_PAIR_W-1:0]  rsp_data_d;
   logic                    rsp_tog_q;
   logic                    rsp_tog_d;
   logic                    rack_s1_q;
   logic                    rack_s2_q;

   // a record is acknowledged only once the buffer takes it, so a stall
   // at the user port backs up into the link crossing
   assign buf_in_valid = (req_s2_q != ack_core_q);

   always_comb begin
      ack_core_d = ack_core_q;
      if (buf_in_valid && buf_in_ready) begin
         ack_core_d = req_s2_q;
      end
   end

   dsp_buf2 #(
      .W (`DSP_REC_W)
   ) u_buf (
      .clk_i       (core_clk_i),
      .nrst_i      (nrst_i),
      .ce_i        (ce_i),
      .in_valid_i  (buf_in_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (rec_q),
      .out_valid_o (buf_out_valid),
      .out_ready_i (usr_req_ready_i),
      .out_data_o  (buf_out_data)
   );

   assign usr_req_valid_o  = buf_out_valid;
   assign usr_req_wr_o     = ~buf_out_data[`DSP_REC_WR_BIT];
   assign usr_req_addr_o   =
      buf_out_data[`DSP_REC_ADDR_LSB +: `DSP_ADDR_W];
   assign usr_req_data_o   =
      buf_out_data[`DSP_REC_DATA_LSB +: `DSP_PAIR_W];
   assign usr_req_mask_n_o =
      buf_out_data[`DSP_REC_MASK_LSB +: `DSP_MASK_W];

   always_comb begin
      rsp_st_d   = rsp_st_q;
      rsp_data_d = rsp_data_q;
      rsp_tog_d  = rsp_tog_q;
      case (rsp_st_q)
         dsp_pkg::DSP_RSP_IDLE: begin
            if (usr_rsp_valid_i) begin
               rsp_data_d = usr_rsp_data_i;
               rsp_tog_d  = ~rsp_tog_q;
               rsp_st_d   = dsp_pkg::DSP_RSP_WAIT;
            end
         end
         dsp_pkg::DSP_RSP_WAIT: begin
            if (rack_s2_q == rsp_tog_q) begin
               rsp_st_d = dsp_pkg::DSP_RSP_IDLE;
            end
         end
         default: begin
            rsp_st_d = dsp_pkg::DSP_RSP_IDLE;
         end
      endcase
   end

   assign usr_rsp_ready_o = (rsp_st_q == dsp_pkg::DSP_RSP_IDLE);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_s1_q   <= 1'b0;
         req_s2_q   <= 1'b0;
         ack_core_q <= 1'b0;
         rsp_st_q   <= dsp_pkg::DSP_RSP_IDLE;
         rsp_data_q <= '0;
         rsp_tog_q  <= 1'b0;
         rack_s1_q  <= 1'b0;
         rack_s2_q  <= 1'b0;
      end else if (ce_i) begin
         req_s1_q   <= req_tog_q;
         req_s2_q   <= req_s1_q;
         ack_core_q <= ack_core_d;
         rsp_st_q   <= rsp_st_d;
         rsp_data_q <= rsp_data_d;
         rsp_tog_q  <= rsp_tog_d;
         rack_s1_q  <= l_seen_q;
         rack_s2_q  <= rack_s1_q;
      end
   end

   // ---------------- launch domain (output clock pair) ----------------
   logic                    launch_clk;
   logic [1:0]              l_rst_q;
   logic                    l_rst_n;
   logic                    rtog_s1_q;
   logic                    rtog_s2_q;
   logic                    l_seen_d;
   logic [`DSP_DATA_W-1:0]  w0_q;
   logic [`DSP_DATA_W-1:0]  w0_d;
   logic [`DSP_DATA_W-1:0]  w1_q;
   logic [`DSP_DATA_W-1:0]  w1_d;
   logic                    arm_q;
   logic                    arm_d;
   logic [`DSP_DATA_W-1:0]  pos_q;
   logic [`DSP_DATA_W-1:0]  pos_d;
   logic                    pos_tag_q;
   logic                    pos_tag_d;
   logic                    drv_q;
   logic                    drv_d;
   logic [`DSP_DATA_W-1:0]  neg_q;
   logic [`DSP_DATA_W-1:0]  neg_d;
   logic                    neg_tag_q;
   logic                    neg_tag_d;
   logic                    first_out;

   // static strap: the output pair is held high, so the input pair times
   // the reads; switching it while clocks run would glitch the launch clock
   assign launch_clk = c_tied_high_i ? k_clk_i : c_clk_i;

   always_ff @(posedge launch_clk or negedge nrst_i) begin
      if (!nrst_i) begin
         l_rst_q <= 2'h0;
      end else begin
         l_rst_q <= {l_rst_q[0], 1'b1};
      end
   end
   assign l_rst_n = l_rst_q[1];

   assign first_out = (neg_tag_q != pos_tag_q);

   always_comb begin
      l_seen_d  = l_seen_q;
      w0_d      = w0_q;
      w1_d      = w1_q;
      arm_d     = arm_q;
      pos_d     = pos_q;
      pos_tag_d = pos_tag_q;
      drv_d     = 1'b0;
      if (arm_q && first_out) begin
         pos_d     = w1_q;
         pos_tag_d = neg_tag_q;
         arm_d     = 1'b0;
         drv_d     = 1'b1;
      end else if (!arm_q && (rtog_s2_q != l_seen_q)) begin
         // any completed user response arms the output, whether or not a read was loaded
         w0_d     = rsp_data_q[`DSP_DATA_W-1:0];
         w1_d     = rsp_data_q[`DSP_PAIR_W-1:`DSP_DATA_W];
         arm_d    = 1'b1;
         l_seen_d = rtog_s2_q;
      end
   end

   always_ff @(posedge launch_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         rtog_s1_q <= 1'b0;
         rtog_s2_q <= 1'b0;
         l_seen_q  <= 1'b0;
         w0_q      <= '0;
         w1_q      <= '0;
         arm_q     <= 1'b0;
         pos_q     <= '0;
         pos_tag_q <= 1'b0;
         drv_q     <= 1'b0;
      end else begin
         rtog_s1_q <= rsp_tog_q;
         rtog_s2_q <= rtog_s1_q;
         l_seen_q  <= l_seen_d;
         w0_q      <= w0_d;
         w1_q      <= w1_d;
         arm_q     <= arm_d;
         pos_q     <= pos_d;
         pos_tag_q <= pos_tag_d;
         drv_q     <= drv_d;
      end
   end

   always_comb begin
      neg_d     = neg_q;
      neg_tag_d = neg_tag_q;
      if (arm_q && !first_out) begin
         neg_d     = w0_q;
         neg_tag_d = ~neg_tag_q;
      end
   end

   always_ff @(negedge launch_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         neg_q     <= '0;
         neg_tag_q <= 1'b0;
      end else begin
         neg_q     <= neg_d;
         neg_tag_q <= neg_tag_d;
      end
   end

   // word one stands half a period, word two a whole period
   assign rd_bus_out_o = first_out ? neg_q : pos_q;
   assign rd_drive_o   = first_out | drv_q;

   // echo pair follows the launch clock whether or not data is driven
   assign echo_timing_out_o = {~launch_clk, launch_clk};

endmodule : dsp_port
